// >>> ts_rec_pkg.sv
/*
  Constants shared by the event time-stamp recorder: register banks and
  offsets, field positions, reset values, sequencer states and timing.
  Assumes a 50 MHz core clock and a bank/offset register port.
*/
package ts_rec_pkg;

  // ----------------------------------------------------------------------
  // Register banks and offsets
  // ----------------------------------------------------------------------
  localparam logic [2:0] BANK_STAMP     = 3'h2;  // Primary record bank
  localparam logic [2:0] BANK_CTRL      = 3'h3;  // History control bank
  localparam logic [2:0] BANK_HIST_LO   = 3'h4;  // First history bank
  localparam logic [2:0] BANK_HIST_HI   = 3'h7;  // Last history bank
  localparam logic [3:0] OFS_STAMP_LAST = 4'h9;  // Status byte offset
  localparam logic [3:0] OFS_OVERWRITE  = 4'hB;  // Overwrite control
  localparam logic [3:0] OFS_CTRL_ONE   = 4'h4;  // history_control_one
  localparam logic [3:0] OFS_CTRL_TWO   = 4'h5;  // history_control_two
  localparam logic [3:0] OFS_CTRL_THREE = 4'h6;  // history_control_three
  localparam int         PRIMARY_BYTES  = 10;    // Bytes 0h..9h
  localparam int         SLOT_BYTES     = 8;     // Bytes per history slot

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BIT_HIST_SELECT  = 0;  // history_control_one
  localparam int BIT_HIST_CLEAR   = 1;
  localparam int BIT_INT_SELECT   = 2;
  localparam int BIT_OSC_REC_EN   = 0;  // history_control_two
  localparam int BIT_SUPPLY_REC_EN = 2;
  localparam int BIT_FULL         = 4;  // history_control_three
  localparam int BIT_EMPTY        = 3;
  localparam int BIT_STAT_SUPPLY  = 3;  // Status byte
  localparam int BIT_STAT_OSC     = 1;
  localparam int BIT_OVERWRITE    = 1;  // Overwrite control register

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] SLOT_PTR_RESET = 3'h7;
  localparam logic       EMPTY_RESET    = 1'b1;
  localparam logic       FULL_RESET     = 1'b0;
  localparam logic [7:0] BYTE_RESET     = 8'h00;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_KHZ      = 50000;
  localparam int OSC_STOP_TIME_US  = 10000;  // Least stop time to flag
  localparam int OSC_STOP_CYCLES   = (OSC_STOP_TIME_US * CLK_FREQ_KHZ + 999) / 1000;

  // ----------------------------------------------------------------------
  // History copy sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_WRITE = 2'b01
  } seq_state_e;

endpackage : ts_rec_pkg

// >>> ts_hist_mem.sv
/*
  Small single-write, single-read memory holding banks 4 to 7, used either
  as user memory or as the history record area. Read data is registered.
  Assumes the caller arbitrates the single write port.
*/
`timescale 1ns/100ps
module ts_hist_mem #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 6
) (
  input  wire logic              clk_in,      // Core clock
  input  wire logic              rst_n_in,    // Async reset, active low
  input  wire logic              wr_en_in,    // Write strobe
  input  wire logic [ADDR_W-1:0] wr_addr_in,  // Write address
  input  wire logic [DATA_W-1:0] wr_data_in,  // Write data
  input  wire logic [ADDR_W-1:0] rd_addr_in,  // Read address
  output logic      [DATA_W-1:0] rd_data_out  // Registered read data
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] mem_array [2**ADDR_W];

  // Array has no reset: contents are kept across a core reset
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_array[wr_addr_in] <= wr_data_in;
    end
  end

  // Read port registered so the output stands as a clean flop
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= mem_array[rd_addr_in];
    end
  end

endmodule : ts_hist_mem

// >>> rtc_event_time_stamp_recorder.sv
/*
  Event time-stamp recorder: latches the calendar time and a status byte
  on supply-low, oscillator-stop or bus-trigger events into a primary
  record and optionally into an eight-slot history memory.
  Assumes time inputs come from calendar logic on CLK_IN, register
  accesses arrive already decoded from the serial bus as single-cycle
  strobes, and the supply and oscillator status come from pins.
*/
`timescale 1ns/100ps

// Functional notes
// - Each event captures ten bytes at 0h-9h
// - Status byte: supply-low bit3, osc-stop bit1
// - Supply-low bit is 1 below threshold
// - Osc-stop bit set after stop over 10 ms
// - Oscillator-stop record deferred until oscillation resumes
// - Supply-low enable gates supply-low records
// - Osc-stop enable gates oscillator-stop records
// - History holds at most eight records
// - History omits 1/1024 and weekday bytes
// - Select low: banks 4-7 are user memory
// - Select high: banks 4-7 hold history
// - First record goes to primary and slot 0
// - Clear bit reinitialises empty, full, pointer
// - Interrupt per event, or only when full
// - Bus trigger record never asserts interrupt
// - Full flag set once eight slots hold records
// - Sub-second fraction bits layout in 0h, 1h
// - Pointer names latest slot, resets to 111
// - Empty flag set while history holds nothing
// - Overwrite control stops or allows wrapping
module rtc_event_time_stamp_recorder #(
  parameter int OSC_STOP_CYCLES = ts_rec_pkg::OSC_STOP_CYCLES  // 10 ms at 50 MHz
) (
  input  wire logic       CLK_IN,          // 50 MHz core clock
  input  wire logic       RST_N_IN,        // Async reset, active low
  input  wire logic [2:0] REG_BANK_IN,     // Register bank
  input  wire logic [3:0] REG_ADDR_IN,     // Register offset in bank
  input  wire logic       REG_WR_IN,       // Write strobe, one cycle
  input  wire logic       REG_RD_IN,       // Read strobe, one cycle
  input  wire logic [7:0] REG_WDATA_IN,    // Write data
  output logic      [7:0] REG_RDATA_OUT,   // Read data
  output logic            REG_RVALID_OUT,  // Read data valid pulse
  input  wire logic       BUS_TRIGGER_IN,  // Bus command trigger pulse
  input  wire logic       INT_ACK_IN,      // Interrupt release pulse
  input  wire logic       SUPPLY_LOW_IN,   // Pin: supply below threshold
  input  wire logic       OSC_STOP_IN,     // Pin: oscillation absent
  input  wire logic [9:0] SUBSEC_IN,       // Fractions 1/2..1/1024 s
  input  wire logic [7:0] SEC_IN,          // Seconds
  input  wire logic [7:0] MIN_IN,          // Minutes
  input  wire logic [7:0] HOUR_IN,         // Hours
  input  wire logic [7:0] WEEKDAY_IN,      // Weekday
  input  wire logic [7:0] DATE_IN,         // Date
  input  wire logic [7:0] MONTH_IN,        // Month
  input  wire logic [7:0] YEAR_IN,         // Year
  output logic            INT_PIN_OUT,     // Interrupt pin drive value
  output logic            INT_OE_N_OUT     // Low while pulling interrupt low
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // True for banks 4..7, used by the write and read decoders
  function automatic logic is_mem_bank(input logic [2:0] bank);
    is_mem_bank = (bank >= ts_rec_pkg::BANK_HIST_LO) &&
                  (bank <= ts_rec_pkg::BANK_HIST_HI);
  endfunction : is_mem_bank

  // Primary byte that feeds each history byte, skipping 0h and 5h
  function automatic logic [3:0] hist_src(input logic [2:0] idx);
    unique case (idx)
      3'h0: hist_src = 4'h1;
      3'h1: hist_src = 4'h2;
      3'h2: hist_src = 4'h3;
      3'h3: hist_src = 4'h4;
      3'h4: hist_src = 4'h6;
      3'h5: hist_src = 4'h7;
      3'h6: hist_src = 4'h8;
      3'h7: hist_src = 4'h9;
    endcase
  endfunction : hist_src

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic        supply_meta_reg;
  logic        supply_sync_reg;
  logic        supply_prev_reg;
  logic        osc_meta_reg;
  logic        osc_sync_reg;
  logic        osc_prev_reg;
  logic [19:0] osc_count_reg;
  logic        osc_long_reg;
  logic        osc_stop_seen_reg;
  logic        osc_defer_reg;
  logic        req_pend_reg;
  logic        req_event_reg;
  logic [7:0]  prim_reg [ts_rec_pkg::PRIMARY_BYTES];
  logic        hist_select_reg;
  logic        int_select_reg;
  logic        supply_rec_en_reg;
  logic        osc_rec_en_reg;
  logic        overwrite_reg;
  logic [2:0]  slot_ptr_reg;
  logic [2:0]  slot_ptr_next;
  logic        empty_reg;
  logic        full_reg;
  ts_rec_pkg::seq_state_e seq_state_reg;
  logic [2:0]  seq_idx_reg;
  logic [2:0]  seq_slot_reg;
  logic        rd_pend_reg;
  logic        rd_mem_reg;
  logic [7:0]  rd_local_reg;
  logic [7:0]  mem_rdata;
  logic        host_mem_wr;
  logic        seq_wr;
  logic        mem_wr_en;
  logic [5:0]  mem_wr_addr;
  logic [7:0]  mem_wr_data;
  logic        supply_event;
  logic        osc_resume;
  logic        take_record;
  logic        hist_write;
  logic        becomes_full;
  logic        clear_cmd;
  logic [7:0]  stat_byte;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Two flops each; only the second stage feeds any logic
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      supply_meta_reg <= 1'b0;
      supply_sync_reg <= 1'b0;
      osc_meta_reg    <= 1'b0;
      osc_sync_reg    <= 1'b0;
    end else begin
      supply_meta_reg <= SUPPLY_LOW_IN;
      supply_sync_reg <= supply_meta_reg;
      osc_meta_reg    <= OSC_STOP_IN;
      osc_sync_reg    <= osc_meta_reg;
    end
  end

  // Edge history for the synchronised levels
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      supply_prev_reg <= 1'b0;
      osc_prev_reg    <= 1'b0;
    end else begin
      supply_prev_reg <= supply_sync_reg;
      osc_prev_reg    <= osc_sync_reg;
    end
  end

  assign supply_event = supply_sync_reg && !supply_prev_reg && supply_rec_en_reg;
  assign osc_resume   = !osc_sync_reg && osc_prev_reg;

  // ----------------------------------------------------------------------
  // Oscillator-stop qualification
  // ----------------------------------------------------------------------
  // Short glitches of the stop indication are ignored until 10 ms elapse
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      osc_count_reg <= '0;
      osc_long_reg  <= 1'b0;
    end else if (!osc_sync_reg) begin
      osc_count_reg <= '0;
      osc_long_reg  <= 1'b0;
    end else if (osc_count_reg >= 20'(OSC_STOP_CYCLES - 1)) begin
      osc_long_reg  <= 1'b1;
    end else begin
      osc_count_reg <= osc_count_reg + 20'h00001;
    end
  end

  // Stop seen is sticky until recorded; a new long stop wins over the clear
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      osc_stop_seen_reg <= 1'b0;
    end else if (osc_long_reg) begin
      osc_stop_seen_reg <= 1'b1;
    end else if (take_record) begin
      osc_stop_seen_reg <= 1'b0;
    end
  end

  // Record for a long stop waits for the resume; the long flag lags a cycle
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      osc_defer_reg <= 1'b0;
    end else if (osc_long_reg && osc_sync_reg) begin
      osc_defer_reg <= 1'b1;
    end else if (osc_resume) begin
      osc_defer_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Record request
  // ----------------------------------------------------------------------
  // Requests merge while the history copy is busy; event beats trigger
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      req_pend_reg  <= 1'b0;
      req_event_reg <= 1'b0;
    end else if (supply_event || (osc_resume && osc_defer_reg && osc_rec_en_reg)) begin
      req_pend_reg  <= 1'b1;
      req_event_reg <= 1'b1;
    end else if (BUS_TRIGGER_IN) begin
      req_pend_reg  <= 1'b1;
      req_event_reg <= req_event_reg && req_pend_reg && !take_record;
    end else if (take_record) begin
      req_pend_reg  <= 1'b0;
      req_event_reg <= 1'b0;
    end
  end

  assign take_record = req_pend_reg && (seq_state_reg == ts_rec_pkg::SEQ_IDLE);
  assign hist_write  = take_record && hist_select_reg &&
                       (!full_reg || overwrite_reg);
  assign slot_ptr_next = slot_ptr_reg + 3'h1;
  assign becomes_full  = hist_write && (slot_ptr_next == 3'h7) && !full_reg;

  // ----------------------------------------------------------------------
  // Primary record capture
  // ----------------------------------------------------------------------
  always_comb begin
    stat_byte = 8'h00;
    stat_byte[ts_rec_pkg::BIT_STAT_SUPPLY] = supply_sync_reg;
    stat_byte[ts_rec_pkg::BIT_STAT_OSC]    = osc_stop_seen_reg;
  end

  // All ten bytes are taken on one edge so the time is coherent
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      for (int i = 0; i < ts_rec_pkg::PRIMARY_BYTES; i++) begin
        prim_reg[i] <= ts_rec_pkg::BYTE_RESET;
      end
    end else if (take_record) begin
      prim_reg[0] <= {6'h00, SUBSEC_IN[1:0]};
      prim_reg[1] <= SUBSEC_IN[9:2];
      prim_reg[2] <= SEC_IN;
      prim_reg[3] <= MIN_IN;
      prim_reg[4] <= HOUR_IN;
      prim_reg[5] <= WEEKDAY_IN;
      prim_reg[6] <= DATE_IN;
      prim_reg[7] <= MONTH_IN;
      prim_reg[8] <= YEAR_IN;
      prim_reg[9] <= stat_byte;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  assign clear_cmd = REG_WR_IN && (REG_BANK_IN == ts_rec_pkg::BANK_CTRL) &&
                     (REG_ADDR_IN == ts_rec_pkg::OFS_CTRL_ONE) &&
                     REG_WDATA_IN[ts_rec_pkg::BIT_HIST_CLEAR];

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      hist_select_reg   <= 1'b0;
      int_select_reg    <= 1'b0;
      supply_rec_en_reg <= 1'b0;
      osc_rec_en_reg    <= 1'b0;
      overwrite_reg     <= 1'b0;
    end else if (REG_WR_IN) begin
      if (REG_BANK_IN == ts_rec_pkg::BANK_CTRL &&
          REG_ADDR_IN == ts_rec_pkg::OFS_CTRL_ONE) begin
        hist_select_reg <= REG_WDATA_IN[ts_rec_pkg::BIT_HIST_SELECT];
        int_select_reg  <= REG_WDATA_IN[ts_rec_pkg::BIT_INT_SELECT];
      end
      if (REG_BANK_IN == ts_rec_pkg::BANK_CTRL &&
          REG_ADDR_IN == ts_rec_pkg::OFS_CTRL_TWO) begin
        supply_rec_en_reg <= REG_WDATA_IN[ts_rec_pkg::BIT_SUPPLY_REC_EN];
        osc_rec_en_reg    <= REG_WDATA_IN[ts_rec_pkg::BIT_OSC_REC_EN];
      end
      if (REG_BANK_IN == ts_rec_pkg::BANK_STAMP &&
          REG_ADDR_IN == ts_rec_pkg::OFS_OVERWRITE) begin
        overwrite_reg <= REG_WDATA_IN[ts_rec_pkg::BIT_OVERWRITE];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Slot pointer and flags
  // ----------------------------------------------------------------------
  // A record in the clear cycle is kept: it lands after the clear
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      slot_ptr_reg <= ts_rec_pkg::SLOT_PTR_RESET;
      empty_reg    <= ts_rec_pkg::EMPTY_RESET;
      full_reg     <= ts_rec_pkg::FULL_RESET;
    end else if (hist_write) begin
      slot_ptr_reg <= clear_cmd ? 3'h0 : slot_ptr_next;
      empty_reg    <= 1'b0;
      full_reg     <= clear_cmd ? 1'b0 : (full_reg || becomes_full);
    end else if (clear_cmd) begin
      slot_ptr_reg <= ts_rec_pkg::SLOT_PTR_RESET;
      empty_reg    <= ts_rec_pkg::EMPTY_RESET;
      full_reg     <= ts_rec_pkg::FULL_RESET;
    end
  end

  // ----------------------------------------------------------------------
  // History copy sequencer
  // ----------------------------------------------------------------------
  // Host writes own the memory port; the copy just waits a cycle
  assign host_mem_wr = REG_WR_IN && is_mem_bank(REG_BANK_IN);
  assign seq_wr      = (seq_state_reg == ts_rec_pkg::SEQ_WRITE) && !host_mem_wr;
  assign mem_wr_en   = host_mem_wr || seq_wr;
  assign mem_wr_addr = host_mem_wr ? {REG_BANK_IN[1:0], REG_ADDR_IN}
                                   : {seq_slot_reg, seq_idx_reg};
  assign mem_wr_data = host_mem_wr ? REG_WDATA_IN : prim_reg[hist_src(seq_idx_reg)];

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      seq_state_reg <= ts_rec_pkg::SEQ_IDLE;
      seq_idx_reg   <= 3'h0;
      seq_slot_reg  <= 3'h0;
    end else begin
      unique case (seq_state_reg)
        ts_rec_pkg::SEQ_IDLE: begin
          if (hist_write) begin
            seq_state_reg <= ts_rec_pkg::SEQ_WRITE;
            seq_idx_reg   <= 3'h0;
            seq_slot_reg  <= clear_cmd ? 3'h0 : slot_ptr_next;
          end
        end
        ts_rec_pkg::SEQ_WRITE: begin
          if (seq_wr) begin
            seq_idx_reg <= seq_idx_reg + 3'h1;
            if (seq_idx_reg == 3'(ts_rec_pkg::SLOT_BYTES - 1)) begin
              seq_state_reg <= ts_rec_pkg::SEQ_IDLE;
            end
          end
        end
      endcase
    end
  end

  ts_hist_mem #(
    .DATA_W (8),
    .ADDR_W (6)
  ) u_hist_mem (
    .clk_in      (CLK_IN),
    .rst_n_in    (RST_N_IN),
    .wr_en_in    (mem_wr_en),
    .wr_addr_in  (mem_wr_addr),
    .wr_data_in  (mem_wr_data),
    .rd_addr_in  ({REG_BANK_IN[1:0], REG_ADDR_IN}),
    .rd_data_out (mem_rdata)
  );

  // ----------------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------------
  // Bus triggers carry no event mark, so they never reach the pin
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      INT_PIN_OUT  <= 1'b0;  // Open drain: only ever pulls low
      INT_OE_N_OUT <= 1'b1;
    end else if (take_record && req_event_reg &&
                 (!int_select_reg || becomes_full)) begin
      INT_OE_N_OUT <= 1'b0;
    end else if (INT_ACK_IN) begin
      INT_OE_N_OUT <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Two-stage read so memory and register data share one latency
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rd_pend_reg  <= 1'b0;
      rd_mem_reg   <= 1'b0;
      rd_local_reg <= 8'h00;
    end else begin
      rd_pend_reg  <= REG_RD_IN;
      rd_mem_reg   <= is_mem_bank(REG_BANK_IN);
      rd_local_reg <= 8'h00;
      if (REG_BANK_IN == ts_rec_pkg::BANK_STAMP) begin
        if (REG_ADDR_IN <= ts_rec_pkg::OFS_STAMP_LAST) begin
          rd_local_reg <= prim_reg[REG_ADDR_IN];
        end else if (REG_ADDR_IN == ts_rec_pkg::OFS_OVERWRITE) begin
          rd_local_reg[ts_rec_pkg::BIT_OVERWRITE] <= overwrite_reg;
        end
      end else if (REG_BANK_IN == ts_rec_pkg::BANK_CTRL) begin
        if (REG_ADDR_IN == ts_rec_pkg::OFS_CTRL_TWO) begin
          rd_local_reg[ts_rec_pkg::BIT_SUPPLY_REC_EN] <= supply_rec_en_reg;
          rd_local_reg[ts_rec_pkg::BIT_OSC_REC_EN]    <= osc_rec_en_reg;
        end else if (REG_ADDR_IN == ts_rec_pkg::OFS_CTRL_THREE) begin
          rd_local_reg <= {3'h0, full_reg, empty_reg, slot_ptr_reg};
        end
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      REG_RDATA_OUT  <= 8'h00;
      REG_RVALID_OUT <= 1'b0;
    end else begin
      REG_RVALID_OUT <= rd_pend_reg;
      if (rd_pend_reg) begin
        REG_RDATA_OUT <= rd_mem_reg ? mem_rdata : rd_local_reg;  // Held until next read
      end
    end
  end

endmodule : rtc_event_time_stamp_recorder

// >>> rtc_ts_monitor.sv
/* Port checker for the event time-stamp recorder.
   Assumes one clock and a bind from the testbench top file. */
`timescale 1ns/100ps
module rtc_ts_monitor (
  input wire logic       CLK_IN,          // Clock
  input wire logic       RST_N_IN,        // Reset
  input wire logic [2:0] REG_BANK_IN,     // Bank
  input wire logic [3:0] REG_ADDR_IN,     // Offset
  input wire logic       REG_RD_IN,       // Read strobe
  input wire logic [7:0] REG_RDATA_OUT,   // Read data
  input wire logic       REG_RVALID_OUT,  // Read valid
  input wire logic       BUS_TRIGGER_IN,  // Trigger
  input wire logic       INT_ACK_IN,      // Release
  input wire logic       SUPPLY_LOW_IN,   // Supply pin
  input wire logic       OSC_STOP_IN,     // Osc pin
  input wire logic       INT_PIN_OUT,     // Drive value
  input wire logic       INT_OE_N_OUT     // Enable, low
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // A read is answered two edges later, never earlier
  sequence s_answer;
    ##2 REG_RVALID_OUT;
  endsequence
  a_read_answer: assert property (REG_RD_IN |-> s_answer)
    else $error("read not answered");
  a_valid_cause: assert property (REG_RVALID_OUT |-> $past(REG_RD_IN, 2))
    else $error("stray read valid");
  a_ctrl3_spare: assert property (REG_RD_IN && REG_BANK_IN == 3'h3 && REG_ADDR_IN == 4'h6
    |-> ##2 REG_RDATA_OUT[7:5] == 3'h0) else $error("control three spare bits");
  a_status_spare: assert property (REG_RD_IN && REG_BANK_IN == 3'h2 && REG_ADDR_IN == 4'h9
    |-> ##2 (REG_RDATA_OUT & 8'hF5) == 8'h00) else $error("status spare bits");
  a_subsec_spare: assert property (REG_RD_IN && REG_BANK_IN == 3'h2 && REG_ADDR_IN == 4'h0
    |-> ##2 REG_RDATA_OUT[7:2] == 6'h00) else $error("fraction spare bits");
  a_int_drive: assert property (!INT_OE_N_OUT |-> !INT_PIN_OUT)
    else $error("interrupt not pulled low");
  a_int_holds: assert property (!INT_OE_N_OUT && !INT_ACK_IN |=> !INT_OE_N_OUT)
    else $error("interrupt dropped early");
  a_trig_quiet: assert property (BUS_TRIGGER_IN && INT_OE_N_OUT && !SUPPLY_LOW_IN
    && !OSC_STOP_IN |=> INT_OE_N_OUT [*4]) else $error("trigger raised interrupt");
endmodule : rtc_ts_monitor

// >>> ts_host_model.sv
/* Host model: byte reads and writes on the register strobes.
   Assumes requests are sampled on the rising clock edge. */
`timescale 1ns/100ps
module ts_host_model (
  input  wire logic clk_in,                 // Clock
  output logic [2:0] bank_out  = 3'h0,      // Bank
  output logic [3:0] addr_out  = 4'h0,      // Offset
  output logic       wr_out    = 1'b0,      // Write strobe
  output logic       rd_out    = 1'b0,      // Read strobe
  output logic [7:0] wdata_out = 8'h00      // Write data
);
  // One strobe per call, held up to its sampling edge
  task automatic acc(input logic w, input logic [2:0] b, input logic [3:0] a,
                     input logic [7:0] d);
    @(posedge clk_in);
    #1;
    {bank_out, addr_out, wdata_out} = {b, a, d};
    {wr_out, rd_out} = {w, !w};
    @(posedge clk_in);
    #1;
    {wr_out, rd_out} = 2'b00;
    wdata_out = ~d;  // Released data never keeps its old value
  endtask : acc
endmodule : ts_host_model

// >>> tb_rtc_event_time_stamp_recorder.sv
/* Testbench: host model on the strobes, pins and calendar driven here.
   Assumes a 50 MHz clock and a shortened oscillator-stop count. */
`timescale 1ns/100ps
module tb_rtc_event_time_stamp_recorder;
  logic       clk_in = 1'b0;
  logic       rst_n = 1'b0, trig = 1'b0, ack = 1'b0, sup = 1'b0, osc = 1'b0;
  logic [9:0] sub = 10'h000;
  logic [7:0] t [7] = '{default: 8'h00};
  logic [7:0] exp_q [$];
  wire  [2:0] bank;
  wire  [3:0] addr;
  wire  [7:0] wdata, rdata;
  wire        wr, rd, rvalid, int_pin, int_oe_n;
  wire        int_wire = int_oe_n ? 1'b1 : int_pin;  // Pull-up when released
  int         n_mismatch = 0, total_checks = 0, cyc = 0;
  always #10 clk_in = ~clk_in;
  ts_host_model u_host (.clk_in, .bank_out(bank), .addr_out(addr), .wr_out(wr),
                        .rd_out(rd), .wdata_out(wdata));
  rtc_event_time_stamp_recorder #(.OSC_STOP_CYCLES(20)) u_dut (
    .CLK_IN(clk_in), .RST_N_IN(rst_n), .REG_BANK_IN(bank), .REG_ADDR_IN(addr),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
    .REG_RVALID_OUT(rvalid), .BUS_TRIGGER_IN(trig), .INT_ACK_IN(ack),
    .SUPPLY_LOW_IN(sup), .OSC_STOP_IN(osc), .SUBSEC_IN(sub), .SEC_IN(t[0]),
    .MIN_IN(t[1]), .HOUR_IN(t[2]), .WEEKDAY_IN(t[3]), .DATE_IN(t[4]),
    .MONTH_IN(t[5]), .YEAR_IN(t[6]), .INT_PIN_OUT(int_pin), .INT_OE_N_OUT(int_oe_n));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] e);
    total_checks++;
    if (seen !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, e, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : wait_n
  // Note the expectation, then issue the read
  task automatic rdx(input logic [2:0] b, input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.acc(1'b0, b, a, 8'h00);
  endtask : rdx
  task automatic rec(input logic [7:0] st);
    logic [7:0] e [10];
    e = '{{6'h00, sub[1:0]}, sub[9:2], t[0], t[1], t[2], t[3], t[4], t[5], t[6], st};
    for (int i = 0; i < 10; i++) rdx(3'h2, 4'(i), e[i]);
  endtask : rec
  task automatic int_is(input logic e);
    check("interrupt line", {7'h00, int_wire}, {7'h00, e});
    ack = 1'b1;
    wait_n(1);
    ack = 1'b0;
  endtask : int_is
  task automatic done(input string s);
    wait_n(4);
    $display("test %s done", s);
  endtask : done
  // Answers taken at the falling edge, clear of the launch edge
  always @(negedge clk_in) begin
    if (rvalid === 1'b1) check("read data", rdata, exp_q.pop_front());
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(32'h98C2));
    sub = 10'($urandom);
    foreach (t[i]) t[i] = 8'($urandom);
    wait_n(5);
    rst_n = 1'b1;
    rdx(3'h3, 4'h6, 8'h0F);
    rdx(3'h3, 4'h4, 8'h00);  // Write-only control reads zero
    rdx(3'h0, 4'h0, 8'h00);  // Unmapped bank reads zero
    done("reset");
    u_host.acc(1'b1, 3'h3, 4'h5, 8'h05);
    u_host.acc(1'b1, 3'h3, 4'h4, 8'h01);
    sup = 1'b1;
    wait_n(12);
    int_is(1'b0);
    rec(8'h08);
    rdx(3'h4, 4'h0, sub[9:2]);
    rdx(3'h4, 4'h4, t[4]);
    rdx(3'h3, 4'h6, 8'h00);
    sup = 1'b0;
    done("supply");
    trig = 1'b1;
    wait_n(1);
    trig = 1'b0;
    wait_n(12);
    int_is(1'b1);
    rdx(3'h3, 4'h6, 8'h01);
    osc = 1'b1;
    wait_n(40);
    rdx(3'h3, 4'h6, 8'h01);
    osc = 1'b0;
    wait_n(12);
    int_is(1'b0);
    rec(8'h02);
    done("oscillator");
    u_host.acc(1'b1, 3'h3, 4'h4, 8'h03);
    u_host.acc(1'b1, 3'h3, 4'h5, 8'h01);
    u_host.acc(1'b1, 3'h4, 4'h0, 8'h00);
    sup = 1'b1;
    wait_n(12);
    rdx(3'h3, 4'h6, 8'h0F);
    rdx(3'h4, 4'h0, 8'h00);
    done("clear");
    repeat (9) begin
      trig = 1'b1;
      wait_n(1);
      trig = 1'b0;
      wait_n(10);
    end
    rdx(3'h3, 4'h6, 8'h17);
    done("full");
    report_and_stop();
  end
endmodule : tb_rtc_event_time_stamp_recorder
bind rtc_event_time_stamp_recorder rtc_ts_monitor u_mon (.CLK_IN, .RST_N_IN, .REG_BANK_IN,
  .REG_ADDR_IN, .REG_RD_IN, .REG_RDATA_OUT, .REG_RVALID_OUT, .BUS_TRIGGER_IN, .INT_ACK_IN,
  .SUPPLY_LOW_IN, .OSC_STOP_IN, .INT_PIN_OUT, .INT_OE_N_OUT);
